// File: rtl/cswk_filter.sv
// selective-wake frame decoder, error counter, flags and sleep sub-modes
`timescale 1ns/100ps
module cswk_filter (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // bus bit samples, one strobe per bit time
    input wire logic i_rx_bit,
    input wire logic i_bit_stb,
    // configuration and software controls
    input wire cswk_pkg::cswk_cfg_t i_cfg,
    input wire logic i_cfg_write,
    input wire logic i_selective_wake_enable,
    input wire logic i_confirm_set,
    input wire logic i_timeout_clr,
    input wire logic i_silence_expired,
    // mode commands
    input wire logic i_sleep_cmd,
    input wire logic i_standby_cmd,
    // status
    output cswk_pkg::cswk_stat_t o_stat,
    output cswk_pkg::cswk_mode_t o_mode,
    output logic o_wake
);
    ////////////////////////////////////////////////////////////////////
    // checksum step, used for every destuffed bit
    function automatic logic [14:0] crc_step(input logic [14:0] c,
                                             input logic b);
        logic [14:0] s;
        s = {c[13:0], 1'b0};
        crc_step = (b ^ c[14]) ? (s ^ cswk_pkg::CRC_POLY) : s;
    endfunction : crc_step

    cswk_pkg::cswk_dec_t st_r, st_nxt;
    cswk_pkg::cswk_mode_t mode_r, mode_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic [28:0] id_r, id_nxt;
    logic ide_r, ide_nxt;
    logic rtr_r, rtr_nxt;
    logic [3:0] dlc_r, dlc_nxt;
    logic hit_r, hit_nxt;
    logic [14:0] crc_r;
    logic last_r;
    logic [2:0] run_r;
    logic [5:0] ecnt_r;
    logic en_r, sil_r, once_r, wake_r;
    logic sys_err_r, sync_r, tmo_r, act_r, conf_r;

    ////////////////////////////////////////////////////////////////////
    // bit classification; a checksum ending in five equal bits is
    // followed by a stuff bit, so the delimiter slot may hold one first
    wire stuff_slot = run_r == cswk_pkg::STUFF_RUN;
    wire stuffed = (st_r != cswk_pkg::CSWK_IDLE) &&
                   (st_r != cswk_pkg::CSWK_SKIP) &&
                   (st_r != cswk_pkg::CSWK_CRCDEL || stuff_slot);
    wire stuff_err = i_bit_stb && stuffed && stuff_slot &&
                     (i_rx_bit == last_r); // R5
    wire dbit = i_bit_stb && stuffed && !stuff_slot;
    wire sof = i_bit_stb && (st_r == cswk_pkg::CSWK_IDLE) && !i_rx_bit;
    wire del_stb = i_bit_stb && (st_r == cswk_pkg::CSWK_CRCDEL) &&
                   !stuff_slot;
    wire crc_ok = del_stb && i_rx_bit && (crc_r == 15'h0000);

    // frame verdicts: fast frames leave before the delimiter once a data-phase baud ratio is set
    wire ev_ok = crc_ok;
    wire ev_err = stuff_err || (del_stb && !crc_ok); // R5 R4
    wire fd_seen = (i_cfg.data_phase_baud_ratio != 3'h0) && i_rx_bit; // R12

    // evaluation of the stored frame against the configuration
    wire [3:0] nbytes = (dlc_r > cswk_pkg::DLC_MAX_BYTES) ?
                        cswk_pkg::DLC_MAX_BYTES : dlc_r;
    wire [6:0] dbits = {nbytes, 3'b000};
    wire [5:0] didx = 6'(7'h3F - cnt_r);
    wire cfg_bit = i_cfg.data[didx];
    wire [28:0] idm = (ide_r ? 29'h1FFFFFFF : cswk_pkg::STD_ID_MASK) &
                      i_cfg.mask; // R25
    wire id_ok = (((id_r ^ i_cfg.id) & idm) == 29'h0) &&
                 (ide_r == i_cfg.ide); // R24 R25
    wire dlc_ok = dlc_r == i_cfg.dlc; // R1
    wire wuf = ev_ok && id_ok && dlc_ok && hit_r; // R23

    ////////////////////////////////////////////////////////////////////
    // frame decoder next state
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        id_nxt = id_r;
        ide_nxt = ide_r;
        rtr_nxt = rtr_r;
        dlc_nxt = dlc_r;
        hit_nxt = hit_r;
        if (sof) begin
            st_nxt = cswk_pkg::CSWK_ID;
            cnt_nxt = 7'h00;
            id_nxt = 29'h0;
            hit_nxt = 1'b0;
            dlc_nxt = 4'h0;
        end else if (stuff_err || del_stb) begin
            st_nxt = cswk_pkg::CSWK_SKIP;
            cnt_nxt = 7'h00;
        end else if (i_bit_stb && st_r == cswk_pkg::CSWK_SKIP) begin
            // any dominant bit restarts the recessive run
            cnt_nxt = i_rx_bit ? cnt_r + 7'h01 : 7'h00;
            if (i_rx_bit && cnt_r == cswk_pkg::SKIP_EOF_BITS - 7'h01) begin
                st_nxt = cswk_pkg::CSWK_IDLE; // R11
            end
        end else if (dbit) begin
            unique case (st_r)
                cswk_pkg::CSWK_ID, cswk_pkg::CSWK_EXT: begin
                    id_nxt = {id_r[27:0], i_rx_bit};
                    cnt_nxt = cnt_r + 7'h01;
                    if (st_r == cswk_pkg::CSWK_ID &&
                        cnt_r == cswk_pkg::STD_ID_LAST) begin
                        st_nxt = cswk_pkg::CSWK_SRR;
                        cnt_nxt = 7'h00;
                    end else if (st_r == cswk_pkg::CSWK_EXT &&
                                 cnt_r == cswk_pkg::EXT_ID_LAST) begin
                        st_nxt = cswk_pkg::CSWK_RTR;
                        cnt_nxt = 7'h00;
                    end
                end
                cswk_pkg::CSWK_SRR: begin
                    rtr_nxt = i_rx_bit;
                    st_nxt = cswk_pkg::CSWK_IDE;
                end
                cswk_pkg::CSWK_IDE: begin
                    ide_nxt = i_rx_bit;
                    st_nxt = i_rx_bit ? cswk_pkg::CSWK_EXT :
                                        cswk_pkg::CSWK_FDF;
                end
                cswk_pkg::CSWK_RTR: begin
                    rtr_nxt = i_rx_bit;
                    st_nxt = cswk_pkg::CSWK_FDF;
                end
                cswk_pkg::CSWK_FDF: begin
                    // with a data-phase baud ratio set, a fast frame is dropped here and never reaches
                    // the verdict, so the counter cannot see it
                    if (fd_seen) begin
                        st_nxt = cswk_pkg::CSWK_SKIP; // R10 R4
                    end else begin
                        st_nxt = ide_r ? cswk_pkg::CSWK_R0 :
                                         cswk_pkg::CSWK_DLC; // R10
                    end
                    cnt_nxt = 7'h00;
                end
                cswk_pkg::CSWK_R0: begin
                    st_nxt = cswk_pkg::CSWK_DLC;
                end
                cswk_pkg::CSWK_DLC: begin
                    dlc_nxt = {dlc_r[2:0], i_rx_bit};
                    cnt_nxt = cnt_r + 7'h01;
                    if (cnt_r == cswk_pkg::DLC_LAST) begin
                        cnt_nxt = 7'h00;
                        st_nxt = (rtr_r || dlc_nxt == 4'h0) ?
                                 cswk_pkg::CSWK_CRC : cswk_pkg::CSWK_DATA;
                    end
                end
                cswk_pkg::CSWK_DATA: begin
                    // sticky hit: comparison is over once one bit matches
                    hit_nxt = hit_r || (i_rx_bit && cfg_bit); // R2
                    cnt_nxt = cnt_r + 7'h01;
                    if (cnt_r == dbits - 7'h01) begin
                        st_nxt = cswk_pkg::CSWK_CRC;
                        cnt_nxt = 7'h00;
                    end
                end
                cswk_pkg::CSWK_CRC: begin
                    cnt_nxt = cnt_r + 7'h01;
                    if (cnt_r == cswk_pkg::CRC_LAST) begin
                        st_nxt = cswk_pkg::CSWK_CRCDEL;
                    end
                end
                default: st_nxt = cswk_pkg::CSWK_SKIP;
            endcase
        end
    end

    // decoder registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= cswk_pkg::CSWK_SKIP;
            cnt_r <= 7'h00;
            id_r <= 29'h0;
            ide_r <= 1'b0;
            rtr_r <= 1'b0;
            dlc_r <= 4'h0;
            hit_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            id_r <= id_nxt;
            ide_r <= ide_nxt;
            rtr_r <= rtr_nxt;
            dlc_r <= dlc_nxt;
            hit_r <= hit_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stuff run tracking and checksum over destuffed bits
    wire same = i_rx_bit == last_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_r <= 1'b1;
            run_r <= 3'h0;
            crc_r <= 15'h0000;
        end else if (sof) begin
            last_r <= 1'b0;
            run_r <= 3'h1;
            crc_r <= 15'h0000;
        end else if (i_bit_stb && stuffed) begin
            last_r <= i_rx_bit;
            run_r <= (same && !stuff_slot) ? run_r + 3'h1 : 3'h1;
            if (dbit) begin
                crc_r <= crc_step(crc_r, i_rx_bit);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sleep sub-mode selection and wake decision
    wire en_rise = i_selective_wake_enable && !en_r;
    wire sil_rise = i_silence_expired && !sil_r;
    wire wake_now = (mode_r == cswk_pkg::CSWK_SWK) &&
                    (wuf || ecnt_r >= cswk_pkg::ECNT_WAKE); // R8 R23
    wire in_sw = (mode_r == cswk_pkg::CSWK_SWK) ||
                 (mode_r == cswk_pkg::CSWK_SSLEEP);
    wire leave_sw = in_sw && (mode_nxt == cswk_pkg::CSWK_AWAKE);
    wire cfg_err = i_cfg_write && conf_r; // R9

    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            cswk_pkg::CSWK_AWAKE: begin
                if (i_sleep_cmd) begin
                    mode_nxt = sys_err_r ? cswk_pkg::CSWK_WUP :
                                           cswk_pkg::CSWK_SWK; // R14
                end
            end
            cswk_pkg::CSWK_SWK: begin
                if (wake_now || i_standby_cmd) begin
                    mode_nxt = cswk_pkg::CSWK_AWAKE;
                end else if (sil_rise) begin
                    mode_nxt = cswk_pkg::CSWK_SSLEEP;
                end
            end
            cswk_pkg::CSWK_SSLEEP: begin
                if (i_standby_cmd) begin
                    mode_nxt = cswk_pkg::CSWK_AWAKE;
                end else if (!i_silence_expired) begin
                    mode_nxt = cswk_pkg::CSWK_SWK;
                end
            end
            cswk_pkg::CSWK_WUP: begin
                if (i_standby_cmd) begin
                    mode_nxt = cswk_pkg::CSWK_AWAKE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // frame error counter, saturating at both ends
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ecnt_r <= 6'h00;
        end else if (en_rise || sil_rise) begin
            ecnt_r <= 6'h00; // R7
        end else if (i_selective_wake_enable) begin // R6
            if (ev_err && ecnt_r != cswk_pkg::ECNT_MAX) begin
                ecnt_r <= ecnt_r + 6'h01; // R3 R26
            end else if (ev_ok && ecnt_r != 6'h00) begin
                ecnt_r <= ecnt_r - 6'h01; // R3 R26
            end
        end
    end

    // mode and flag registers; every hardware set beats its clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_r <= cswk_pkg::CSWK_AWAKE;
            en_r <= 1'b0;
            sil_r <= 1'b0;
            once_r <= 1'b0;
            wake_r <= 1'b0;
            sys_err_r <= 1'b0;
            sync_r <= 1'b0;
            tmo_r <= 1'b0;
            act_r <= 1'b0;
            conf_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            en_r <= i_selective_wake_enable;
            sil_r <= i_silence_expired; // R19
            once_r <= once_r || conf_r;
            wake_r <= wake_now;
            if (i_selective_wake_enable && (cfg_err || ecnt_r > 6'h1F)) begin
                sys_err_r <= 1'b1; // R13
            end else if (conf_r && ecnt_r < cswk_pkg::ECNT_WAKE) begin
                sys_err_r <= 1'b0; // R15
            end
            if (ev_ok && i_selective_wake_enable && once_r) begin
                sync_r <= 1'b1; // R16
            end else if (ev_err) begin
                sync_r <= 1'b0; // R17
            end
            // selective sleep is only ever entered by this expiry
            if (i_selective_wake_enable && sil_rise &&
                mode_nxt == cswk_pkg::CSWK_SSLEEP) begin
                tmo_r <= 1'b1; // R18
            end else if (i_timeout_clr) begin
                tmo_r <= 1'b0;
            end
            if (mode_nxt == cswk_pkg::CSWK_AWAKE) begin
                act_r <= 1'b0; // R20
            end else if (mode_r == cswk_pkg::CSWK_AWAKE &&
                         mode_nxt == cswk_pkg::CSWK_SWK) begin
                act_r <= 1'b1; // R20
            end
            if (i_confirm_set) begin
                conf_r <= 1'b1;
            end else if (cfg_err || leave_sw) begin
                conf_r <= 1'b0; // R22
            end
        end
    end

    // outputs, all from flip-flops
    assign o_stat = '{ecnt: ecnt_r, sys_err: sys_err_r, sync: sync_r,
                      bus_timeout: tmo_r, bus_silence: sil_r,
                      active: act_r, confirm: conf_r};
    assign o_mode = mode_r;
    assign o_wake = wake_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ecnt_inc_a: assert property (i_selective_wake_enable && en_r && !sil_rise && ev_err &&
        ecnt_r != cswk_pkg::ECNT_MAX |=> ecnt_r == $past(ecnt_r) + 6'h01)
        else $error("error count did not rise"); // R3
    ecnt_floor_a: assert property (ecnt_r == 6'h00 && !ev_err
        |=> ecnt_r == 6'h00)
        else $error("error count left zero without error"); // R26
    ecnt_clear_a: assert property (i_selective_wake_enable && !en_r |=> ecnt_r == 6'h00)
        else $error("error count not cleared on enable"); // R7
    fd_skip_a: assert property (dbit && st_r == cswk_pkg::CSWK_FDF &&
        fd_seen |=> st_r == cswk_pkg::CSWK_SKIP ##1 !ev_err)
        else $error("fast frame not skipped"); // R10
    sleep_pick_a: assert property (mode_r == cswk_pkg::CSWK_AWAKE &&
        i_sleep_cmd |=> mode_r == ($past(sys_err_r) ?
        cswk_pkg::CSWK_WUP : cswk_pkg::CSWK_SWK))
        else $error("wrong sleep sub-mode"); // R14
    cfg_error_a: assert property (cfg_err && i_selective_wake_enable && !i_confirm_set
        |=> sys_err_r && !conf_r)
        else $error("config error not flagged"); // R9
    sync_clear_a: assert property (ev_err |=> !sync_r)
        else $error("sync kept after bad frame"); // R17
    timeout_hold_a: assert property (tmo_r && !i_timeout_clr |=> tmo_r)
        else $error("timeout flag dropped by itself"); // R18
    count_wake_a: assert property (mode_r == cswk_pkg::CSWK_SWK &&
        ecnt_r >= cswk_pkg::ECNT_WAKE |=> o_wake && mode_r ==
        cswk_pkg::CSWK_AWAKE)
        else $error("no wake at error count 32"); // R8
    active_off_a: assert property (mode_r == cswk_pkg::CSWK_AWAKE |-> !act_r)
        else $error("active flag set while awake"); // R20
endmodule : cswk_filter

// File: pkg/cswk_pkg.sv
// constants, types and field layouts of the selective-wake frame filter
// Operation
// R1 - length evaluation passes only if received length code equals configured one
// R2 - data passes on first received one bit matching a configured one bit
// R3 - error counter rises by 1 per bad classical frame, falls per good
// R4 - flexible-data-rate frames never touch the error counter
// R5 - stuffing violation, checksum mismatch or bad delimiter makes a frame bad
// R6 - counter runs in every mode while wake enable is 1; readable
// R7 - counter clears when wake becomes enabled and when silence timer expires
// R8 - in selective-wake sub-mode, counter reaching 32 wakes the device
// R9 - configuration write after confirm flags a configuration error
// R10 - format bit 1 halts decoding; 0 continues as classical frame
// R11 - after skipped fast frame, 6..10 recessive bits end the frame
// R12 - processor programs data-phase baud ratio before fast frames are skipped
// R13 - with wake enabled, config error or counter above 31 sets system error
// R14 - sleep command always sleeps; system error picks pattern or selective sub-mode
// R15 - system error clears only if confirmed and counter below 32
// R16 - sync flag sets on good frame if enabled and confirmed once
// R17 - sync flag clears on bad frame, zero after power-up, no sleep effect
// R18 - silence expiry in selective sleep sets timeout flag; software clears it
// R19 - silence flag reflects expiry of the silence timer
// R20 - active flag sets entering selective-wake sub-mode, clears leaving sleep
// R21 - processor sets confirm before every sleep meant for selective wake
// R22 - confirm clears going to standby from wake sub-modes and on config error
// R23 - wake frame needs identifier, length/data and checksum all correct
// R24 - identifier compared bit by bit, masked positions skipped
// R25 - configured extension bit selects standard or extended identifier
// R26 - error counter neither goes below zero nor wraps past its maximum
package cswk_pkg;
    localparam int ID_W = 29;
    localparam int DATA_BITS = 64;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [5:0] ECNT_WAKE = 6'h20;
    localparam logic [5:0] ECNT_MAX = 6'h3F;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [6:0] SKIP_EOF_BITS = 7'h06;
    localparam logic [3:0] DLC_MAX_BYTES = 4'h8;
    localparam logic [6:0] STD_ID_LAST = 7'h0A;
    localparam logic [6:0] EXT_ID_LAST = 7'h11;
    localparam logic [6:0] DLC_LAST = 7'h03;
    localparam logic [6:0] CRC_LAST = 7'h0E;
    localparam logic [28:0] STD_ID_MASK = 29'h000007FF;

    typedef enum logic [3:0] {
        CSWK_IDLE = 4'h0, CSWK_ID = 4'h1, CSWK_SRR = 4'h2, CSWK_IDE = 4'h3,
        CSWK_EXT = 4'h4, CSWK_RTR = 4'h5, CSWK_FDF = 4'h6, CSWK_R0 = 4'h7,
        CSWK_DLC = 4'h8, CSWK_DATA = 4'h9, CSWK_CRC = 4'hA,
        CSWK_CRCDEL = 4'hB, CSWK_SKIP = 4'hC
    } cswk_dec_t;

    typedef enum logic [1:0] {
        CSWK_AWAKE = 2'b00, CSWK_SWK = 2'b01, CSWK_SSLEEP = 2'b10,
        CSWK_WUP = 2'b11
    } cswk_mode_t;

    typedef struct packed {
        logic [28:0] id;
        logic [28:0] mask;
        logic ide;
        logic [3:0] dlc;
        logic [63:0] data;
        logic [2:0] data_phase_baud_ratio;
    } cswk_cfg_t;

    typedef struct packed {
        logic [5:0] ecnt;
        logic sys_err;
        logic sync;
        logic bus_timeout;
        logic bus_silence;
        logic active;
        logic confirm;
    } cswk_stat_t;
endpackage : cswk_pkg

// File: testbench/cswk_can_node.sv
// far-side bus node model: classical and fast frames with fault injection
`timescale 1ns/100ps
module cswk_can_node (
    // clock
    input wire logic i_clk,
    // bus bit samples towards the filter
    output logic o_rx_bit,
    output logic o_bit_stb
);
    ////////////////////////////////////////////////////////////////////////
    // the bus bias holds idle recessive; strobes stop between frames
    initial begin
        o_rx_bit = 1'b1;
        o_bit_stb = 1'b0;
    end

    // a bit time is four clocks with one strobe cycle, so edges never race
    task automatic put(input logic b);
        @(negedge i_clk);
        o_rx_bit = b;
        o_bit_stb = 1'b1;
        @(negedge i_clk);
        o_bit_stb = 1'b0;
        repeat (2) @(negedge i_clk);
    endtask : put

    // err: 0 none, 1 checksum flip, 2 dominant delimiter, 3 six dominant
    task automatic send(input logic [28:0] id, input logic ext,
                        input logic fdf, input logic [3:0] dlc,
                        input logic [63:0] d, input int err);
        logic q[$];
        logic [14:0] crc;
        logic last;
        int run;
        q.push_back(1'b0);
        for (int i = 28; i >= 18; i--) q.push_back(ext ? id[i] : id[i - 18]);
        if (ext) begin
            q.push_back(1'b1);
            q.push_back(1'b1);
            for (int i = 17; i >= 0; i--) q.push_back(id[i]);
        end
        q.push_back(1'b0);
        if (!ext) q.push_back(1'b0);
        q.push_back(fdf);
        if (ext) q.push_back(1'b0);
        for (int i = 3; i >= 0; i--) q.push_back(dlc[i]);
        for (int i = 0; i < ((dlc > 8) ? 64 : 8 * dlc); i++) q.push_back(d[63 - i]);
        crc = 15'h0000;
        foreach (q[i]) crc = {crc[13:0], 1'b0} ^
            ((q[i] ^ crc[14]) ? cswk_pkg::CRC_POLY : 15'h0000);
        if (err == 1) crc[0] = ~crc[0];
        for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
        // stuffing covers start bit through checksum end
        run = 0;
        last = 1'b1;
        foreach (q[i]) begin
            if (err == 3 && i == 13) begin
                repeat (6) put(1'b0);
                break;
            end
            put(q[i]);
            run = (q[i] == last) ? run + 1 : 1;
            last = q[i];
            if (run == 5) begin
                put(~last);
                last = ~last;
                run = 1;
            end
        end
        if (err != 3) put(err != 2);
        // acknowledge, end of frame and intermission all recessive
        repeat (11) put(1'b1);
    endtask : send
endmodule : cswk_can_node

// File: testbench/tb_top.sv
// self-checking bench: frames, controls and a flag model of the wake filter
`timescale 1ns/100ps
module tb_top;
    logic i_clk, i_rst, i_rx_bit, i_bit_stb, i_cfg_write, i_selective_wake_enable;
    logic i_confirm_set, i_timeout_clr, i_silence_expired;
    logic i_sleep_cmd, i_standby_cmd, o_wake;
    cswk_pkg::cswk_cfg_t i_cfg;
    cswk_pkg::cswk_stat_t o_stat;
    cswk_pkg::cswk_mode_t o_mode;
    int num_errors = 0;
    int n_tests = 0;
    int m_ecnt, m_err, m_sync, m_tout, m_sil, m_act, m_conf, m_ever, m_mode;
    int m_wake, wake_seen;
    int ops[] = '{1, 2, 5, 6, 0, 0, 3, 0, 1, 5, 6, 4, 2};

    cswk_filter DUT (.i_clk(i_clk), .i_rst(i_rst), .i_rx_bit(i_rx_bit),
        .i_bit_stb(i_bit_stb), .i_cfg(i_cfg), .i_cfg_write(i_cfg_write),
        .i_selective_wake_enable(i_selective_wake_enable), .i_confirm_set(i_confirm_set),
        .i_timeout_clr(i_timeout_clr), .i_silence_expired(i_silence_expired),
        .i_sleep_cmd(i_sleep_cmd), .i_standby_cmd(i_standby_cmd),
        .o_stat(o_stat), .o_mode(o_mode), .o_wake(o_wake));
    cswk_can_node node (.i_clk(i_clk), .o_rx_bit(i_rx_bit),
        .o_bit_stb(i_bit_stb));

    ////////////////////////////////////////////////////////////////////////
    // clock, wake pulse counter and watchdog
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_wake === 1'b1) wake_seen++;
    end
    initial begin
        repeat (90000) @(posedge i_clk);
        num_errors++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input int exp, input logic [7:0] s);
        n_tests++;
        if (8'(exp) !== s) begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, s);
        end
    endtask : chk

    // system error is settled here, since it follows counter and confirm
    task automatic chk_all;
        if (m_ecnt > 31) m_err = 1;
        else if (m_conf == 1 && m_ecnt < 32) m_err = 0;
        chk("ecnt", m_ecnt, 8'(o_stat.ecnt));
        chk("sys_err", m_err, 8'(o_stat.sys_err));
        chk("sync", m_sync, 8'(o_stat.sync));
        chk("bus_timeout", m_tout, 8'(o_stat.bus_timeout));
        chk("bus_silence", m_sil, 8'(o_stat.bus_silence));
        chk("active", m_act, 8'(o_stat.active));
        chk("confirm", m_conf, 8'(o_stat.confirm));
        chk("mode", m_mode, 8'(o_mode));
        chk("wake", m_wake, 8'(wake_seen));
    endtask : chk_all

    // op: 0 confirm, 1 sleep, 2 standby, 3 cfg write, 4 timeout clear,
    // 5 silence expires, 6 silence ends
    task automatic ctl(input int op);
        @(negedge i_clk);
        case (op)
            0: i_confirm_set = 1'b1;
            1: i_sleep_cmd = 1'b1;
            2: i_standby_cmd = 1'b1;
            3: i_cfg_write = 1'b1;
            4: i_timeout_clr = 1'b1;
            default: i_silence_expired = (op == 5);
        endcase
        @(negedge i_clk);
        {i_confirm_set, i_sleep_cmd, i_standby_cmd} = 3'h0;
        {i_cfg_write, i_timeout_clr} = 2'h0;
        repeat (3) @(negedge i_clk);
        if (op == 0) m_ever = 1;
        if (op == 0) m_conf = 1;
        if (op == 1 && m_mode == 0) m_act = (m_err == 0);
        if (op == 1 && m_mode == 0) m_mode = m_err ? 3 : 1;
        if (op == 2 && m_mode inside {1, 2}) m_conf = 0;
        if (op == 2) m_act = 0;
        if (op == 2) m_mode = 0;
        if (op == 3 && m_conf == 1) m_err = 1;
        if (op == 3) m_conf = 0;
        if (op == 4) m_tout = 0;
        if (op == 5 && m_mode == 1) m_tout = 1;
        if (op == 5) m_ecnt = 0;
        if (op == 5 && m_mode == 1) m_mode = 2;
        if (op == 6 && m_mode == 2) m_mode = 1;
        m_sil = (op == 5) ? 1 : (op == 6) ? 0 : m_sil;
        chk_all();
    endtask : ctl

    // send one frame, then advance the model from the frame's own content
    task automatic frame(input logic [28:0] id, input logic ext,
                         input logic fdf, input logic [3:0] dlc,
                         input logic [63:0] d, input int err);
        logic [63:0] keep;
        logic hit;
        logic cls;
        keep = (dlc > 8) ? '1 : ~(64'hFFFFFFFFFFFFFFFF >> (8 * dlc));
        hit = (ext === i_cfg.ide) && (dlc === i_cfg.dlc) &&
            ((d & i_cfg.data & keep) != 64'h0) && (((id ^ i_cfg.id) &
            i_cfg.mask & (ext ? 29'h1FFFFFFF : cswk_pkg::STD_ID_MASK)) == 0);
        // a stuff fault before the format bit still counts as classical
        cls = !fdf || err == 3 || i_cfg.data_phase_baud_ratio == 3'h0;
        node.send(id, ext, fdf, dlc, d, err);
        repeat (2) @(negedge i_clk);
        if (cls && err == 0) m_ecnt = (m_ecnt > 0) ? m_ecnt - 1 : 0;
        if (cls && err == 0 && m_ever == 1) m_sync = 1;
        if (cls && err != 0) m_ecnt = (m_ecnt < 63) ? m_ecnt + 1 : 63;
        if (cls && err != 0) m_sync = 0;
        if (cls && m_mode == 1 && ((err == 0 && hit) || m_ecnt >= 32)) begin
            m_wake++;
            m_mode = 0;
            m_act = 0;
            m_conf = 0;
        end
        chk_all();
    endtask : frame

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {m_ecnt, m_err, m_sync, m_tout, m_sil, m_act} = '0;
        {m_conf, m_ever, m_mode, m_wake, wake_seen} = '0;
        {i_rst, i_selective_wake_enable} = 2'h3;
        {i_cfg_write, i_confirm_set, i_timeout_clr} = 3'h0;
        {i_silence_expired, i_sleep_cmd, i_standby_cmd} = 3'h0;
        void'($urandom(77));
        i_cfg.id = 29'($urandom_range(2047));
        i_cfg.mask = 29'($urandom) | 29'h00000001;
        i_cfg.ide = 1'b0;
        i_cfg.dlc = 4'h1 + 4'($urandom_range(7));
        i_cfg.data = {$urandom, $urandom} | 64'h8000000000000000;
        i_cfg.data_phase_baud_ratio = 3'h2;
        repeat (6) @(negedge i_clk);
        i_rst = 1'b0;
        chk_all();
        // the decoder leaves reset skipping and needs a recessive run
        repeat (6) node.put(1'b1);
        for (int e = 1; e < 4; e++) frame(i_cfg.id, 1'b0, 1'b0, 4'h2, '1, e);
        frame(i_cfg.id, 1'b0, 1'b1, 4'h8, '1, 1);
        frame(i_cfg.id, 1'b0, 1'b0, 4'h1, '0, 0);
        i_cfg.data_phase_baud_ratio = 3'h0;
        frame(i_cfg.id, 1'b0, 1'b1, 4'h1, '0, 1);
        i_cfg.data_phase_baud_ratio = 3'h2;
        // re-enable must clear the count
        @(negedge i_clk);
        i_selective_wake_enable = 1'b0;
        @(negedge i_clk);
        i_selective_wake_enable = 1'b1;
        repeat (3) @(negedge i_clk);
        m_ecnt = 0;
        chk_all();
        ctl(0);
        ctl(1);
        frame(i_cfg.id ^ 29'h1, 1'b0, 1'b0, i_cfg.dlc, i_cfg.data, 0);
        frame(i_cfg.id, 1'b0, 1'b0, i_cfg.dlc ^ 4'h8, i_cfg.data, 0);
        frame(i_cfg.id, 1'b1, 1'b0, i_cfg.dlc, i_cfg.data, 0);
        frame(i_cfg.id, 1'b0, 1'b0, i_cfg.dlc, '0, 0);
        frame(i_cfg.id ^ (29'($urandom) & ~i_cfg.mask & 29'h7FF), 1'b0,
              1'b0, i_cfg.dlc, i_cfg.data, 0);
        ctl(0);
        ctl(1);
        for (int k = 0; k < 12; k++)
            frame(29'($urandom_range(2047)), 1'b0, $urandom_range(3) == 0,
                  4'($urandom), {$urandom, $urandom}, $urandom_range(3));
        ctl(0);
        ctl(1);
        for (int k = 0; k < 66; k++)
            frame(i_cfg.id, 1'b0, 1'b0, 4'h1, '1, 2);
        foreach (ops[k]) ctl(ops[k]);
        print_verdict();
    end
endmodule : tb_top
